// >>> nvmac_pkg.sv
package nvmac_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] NVMAC_OFF_CONTROL = 4'h0;
  localparam logic [3:0] NVMAC_OFF_UNLOCK  = 4'h1;
  localparam logic [3:0] NVMAC_OFF_ADDR_LO = 4'h2;
  localparam logic [3:0] NVMAC_OFF_ADDR_HI = 4'h3;
  localparam logic [3:0] NVMAC_OFF_DATA    = 4'h4;
  localparam logic [3:0] NVMAC_OFF_STATUS  = 4'h5;
  localparam logic [3:0] NVMAC_OFF_MASK    = 4'h6;

  // ---------------------------------------------------------------
  // control register bit positions
  // ---------------------------------------------------------------
  localparam int NVMAC_BIT_PGD   = 7;
  localparam int NVMAC_BIT_CFG   = 6;
  localparam int NVMAC_BIT_ERASE = 4;
  localparam int NVMAC_BIT_ERR   = 3;
  localparam int NVMAC_BIT_PERM  = 2;
  localparam int NVMAC_BIT_WR    = 1;
  localparam int NVMAC_BIT_RD    = 0;

  // status / mask bit positions
  localparam int NVMAC_IRQ_DONE  = 0;
  localparam int NVMAC_IRQ_ERR   = 1;

  // ---------------------------------------------------------------
  // unlock keys, reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] NVMAC_KEY_FIRST  = 8'h55;
  localparam logic [7:0] NVMAC_KEY_SECOND = 8'haa;
  localparam logic [7:0] NVMAC_CTRL_RST   = 8'h00;
  localparam logic [7:0] NVMAC_BYTE_RST   = 8'h00;
  localparam logic [1:0] NVMAC_IRQ_RST    = 2'h0;
  localparam int         NVMAC_CLK_MHZ    = 50;
  localparam int         NVMAC_WRITE_US   = 4;
  localparam int         NVMAC_WRITE_CYC  = NVMAC_WRITE_US * NVMAC_CLK_MHZ;
  localparam logic [15:0] NVMAC_WRITE_CNT = 16'(NVMAC_WRITE_CYC);

  typedef enum logic [1:0] {
    NVMAC_LOCKED,
    NVMAC_KEY1,
    NVMAC_ARMED
  } nvmac_unlock_e;

  typedef struct packed {
    logic       pgd;
    logic       cfg;
    logic       erase;
    logic       err;
    logic       perm;
    logic       wr;
  } nvmac_ctrl_s;

  typedef struct packed {
    nvmac_ctrl_s   ctrl;
    nvmac_unlock_e unl;
    logic [15:0]   cnt;
    logic [7:0]    addr_lo;
    logic [7:0]    addr_hi;
    logic [7:0]    data;
    logic [1:0]    status;
    logic [1:0]    mask;
    logic [7:0]    rdata;
  } nvmac_state_s;

  typedef struct packed {
    logic        we;
    logic        erase;
    logic        pgm;
    logic        cfg;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } nvmac_mem_s;

endpackage

// >>> nvmac_ctrl.sv
// Overview of operation
// - setting write-start begins a write or erase chosen by space select bits
// - cycle is self-timed; hardware clears write-start when it finishes
// - software can only set write-start, writing zero does nothing
// - data read: load address, clear bits 7 and 6, set read bit 0
// - read byte lands in data register for the next cycle
// - data register holds until next read or a software write
// - write completion sets done flag, cleared only by software
// - write starts only after 55h then AAh to unlock then write-start
// - write-start cannot be set unless write permit is already set
// - row-erase bit makes next start erase the row when bit 7 (program memory) is set; completion clears it
module nvmac_ctrl
  import nvmac_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // interrupted-cycle reset causes (external pin, watchdog)
  input  wire logic        ext_reset_req,
  input  wire logic        wdt_reset_req,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // memory array side
  output nvmac_mem_s       mem_cmd,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic [15:0] table_pointer,
  // status
  output logic             write_busy,
  output logic             irq
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // software write to a given register
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off,
                               input logic w);
    return w && (a == off);
  endfunction

  function automatic logic [7:0] ctrl_byte(input nvmac_ctrl_s c);
    logic [7:0] b;
    b = 8'h00;
    b[NVMAC_BIT_PGD]   = c.pgd;
    b[NVMAC_BIT_CFG]   = c.cfg;
    b[NVMAC_BIT_ERASE] = c.erase;
    b[NVMAC_BIT_ERR]   = c.err;
    b[NVMAC_BIT_PERM]  = c.perm;
    b[NVMAC_BIT_WR]    = c.wr;
    return b;
  endfunction

  nvmac_state_s st_reg;
  nvmac_state_s st_next;

  // decoded strobes and cycle events, shared by the sections below
  logic w_ctrl;
  logic start_ok;
  logic rd_start;
  logic done;
  logic cut_req;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // one combinational pass builds the whole next state
  always_comb begin
    st_next  = st_reg;
    w_ctrl   = hit(reg_addr, NVMAC_OFF_CONTROL, reg_wr);
    // permit must already be set before this write
    start_ok = w_ctrl && reg_wdata[NVMAC_BIT_WR] && !st_reg.ctrl.wr
               && st_reg.ctrl.perm
               && (st_reg.unl == NVMAC_ARMED);
    // reads of the data space only; other spaces ignore the read strobe
    rd_start = w_ctrl && reg_wdata[NVMAC_BIT_RD] && !st_reg.ctrl.wr
               && !reg_wdata[NVMAC_BIT_PGD]
               && !reg_wdata[NVMAC_BIT_CFG];
    // count runs down to one, so busy lasts exactly the loaded count
    done     = st_reg.ctrl.wr && (st_reg.cnt == 16'h0001);
    // an abort request outside a cycle has nothing to cut
    cut_req  = (ext_reset_req || wdt_reset_req) && st_reg.ctrl.wr;

    // unlock sequencer: any other write to the unlock reg or any
    // control write breaks the chain, so a stray store cannot arm it
    if (hit(reg_addr, NVMAC_OFF_UNLOCK, reg_wr)) begin
      case (st_reg.unl)
        NVMAC_LOCKED: st_next.unl = (reg_wdata == NVMAC_KEY_FIRST) ?
                                    NVMAC_KEY1 : NVMAC_LOCKED;
        NVMAC_KEY1:   st_next.unl = (reg_wdata == NVMAC_KEY_SECOND) ?
                                    NVMAC_ARMED : NVMAC_LOCKED;
        default:      st_next.unl = NVMAC_LOCKED;
      endcase
    end else if (w_ctrl) begin
      st_next.unl = NVMAC_LOCKED;
    end

    // control register; locked while a cycle runs
    if (w_ctrl && !st_reg.ctrl.wr) begin
      st_next.ctrl.pgd   = reg_wdata[NVMAC_BIT_PGD];
      st_next.ctrl.cfg   = reg_wdata[NVMAC_BIT_CFG];
      st_next.ctrl.erase = reg_wdata[NVMAC_BIT_ERASE];
      st_next.ctrl.err   = reg_wdata[NVMAC_BIT_ERR];
      st_next.ctrl.perm  = reg_wdata[NVMAC_BIT_PERM];
    end
    // start needs permit, armed unlock and a set write-start bit
    if (start_ok) begin
      st_next.ctrl.wr = 1'b1;
      st_next.cnt     = NVMAC_WRITE_CNT;
    end                                              // zero write ignored

    // self-timed cycle
    // erase and write share one duration, no separate erase timer
    if (st_reg.ctrl.wr) begin
      st_next.cnt = st_reg.cnt - 16'h0001;
      if (done) begin
        st_next.ctrl.wr = 1'b0;
        if (st_reg.ctrl.erase) begin
          st_next.ctrl.erase = 1'b0;
        end
      end
    end

    // interrupted cycle: abort, flag, keep selects for retry
    // an abort in the completion cycle still flags the error; the done flag and erase clear happen too
    if (cut_req) begin
      st_next.ctrl.wr  = 1'b0;
      st_next.ctrl.err = 1'b1;
      st_next.cnt      = 16'h0000;
    end

    // address and data registers, frozen during a cycle
    if (!st_reg.ctrl.wr) begin
      if (hit(reg_addr, NVMAC_OFF_ADDR_LO, reg_wr)) begin
        st_next.addr_lo = reg_wdata;
      end
      if (hit(reg_addr, NVMAC_OFF_ADDR_HI, reg_wr)) begin
        st_next.addr_hi = reg_wdata;
      end
      if (hit(reg_addr, NVMAC_OFF_DATA, reg_wr)) begin
        st_next.data = reg_wdata;
      end
    end
    if (rd_start) begin
      st_next.data = mem_rdata;
    end

    // sticky status, write one to clear; set beats clear
    if (hit(reg_addr, NVMAC_OFF_STATUS, reg_wr)) begin
      st_next.status = st_reg.status & ~reg_wdata[1:0];
    end
    if (done) begin
      st_next.status[NVMAC_IRQ_DONE] = 1'b1;
    end
    if (cut_req) begin
      st_next.status[NVMAC_IRQ_ERR] = 1'b1;
    end
    // mask has the status layout
    if (hit(reg_addr, NVMAC_OFF_MASK, reg_wr)) begin
      st_next.mask = reg_wdata[1:0];
    end

    // read data, one cycle after the strobe
    st_next.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        NVMAC_OFF_CONTROL: st_next.rdata = ctrl_byte(st_reg.ctrl);
        NVMAC_OFF_ADDR_LO: st_next.rdata = st_reg.addr_lo;
        NVMAC_OFF_ADDR_HI: st_next.rdata = st_reg.addr_hi;
        NVMAC_OFF_DATA:    st_next.rdata = st_reg.data;
        NVMAC_OFF_STATUS:  st_next.rdata = {6'h00, st_reg.status};
        NVMAC_OFF_MASK:    st_next.rdata = {6'h00, st_reg.mask};
        default:           st_next.rdata = 8'h00; // unlock reads zero
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // async clear to idle; a low ce freezes every field
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg.ctrl    <= nvmac_ctrl_s'(NVMAC_CTRL_RST[5:0]);
      st_reg.unl     <= NVMAC_LOCKED;
      st_reg.cnt     <= 16'h0000;
      st_reg.addr_lo <= NVMAC_BYTE_RST;
      st_reg.addr_hi <= NVMAC_BYTE_RST;
      st_reg.data    <= NVMAC_BYTE_RST;
      st_reg.status  <= NVMAC_IRQ_RST;
      st_reg.mask    <= NVMAC_IRQ_RST;
      st_reg.rdata   <= NVMAC_BYTE_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // array command: address always reflects the pointer registers,
  // or the table pointer for program-memory operations
  always_comb begin
    mem_cmd.we    = st_reg.ctrl.wr;
    mem_cmd.erase = st_reg.ctrl.erase && st_reg.ctrl.pgd;
    mem_cmd.pgm   = st_reg.ctrl.pgd;
    mem_cmd.cfg   = st_reg.ctrl.cfg;
    mem_cmd.addr  = st_reg.ctrl.pgd ? table_pointer
                                    : {st_reg.addr_hi, st_reg.addr_lo};
    mem_cmd.wdata = st_reg.data;
  end

  // register outputs straight from the flops, except irq, the OR of status masked by mask
  assign reg_rdata  = st_reg.rdata;
  assign write_busy = st_reg.ctrl.wr;
  assign irq        = |(st_reg.status & st_reg.mask);

endmodule

// >>> nvmac_chk.sv
module nvmac_chk
  import nvmac_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // watched ports
  input wire logic       ce,
  input wire logic       ext_reset_req,
  input wire logic       wdt_reset_req,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire nvmac_mem_s mem_cmd,
  input wire logic       write_busy
);
  logic [8:0] busy_cnt_reg;

  // busy length counter, a plain repetition would be far too long
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      busy_cnt_reg <= 9'h000;
    else if (ce)
      busy_cnt_reg <= write_busy ? busy_cnt_reg + 9'h001 : 9'h000;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_rd_idle; ce && !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero");
  property p_hold;
    write_busy && !ext_reset_req && !wdt_reset_req
      && busy_cnt_reg < 9'h0c7 |=> write_busy;
  endproperty
  a_hold: assert property (p_hold)
    else $error("write cycle ended early");
  property p_start;
    $rose(write_busy) |-> $past(reg_wr) && $past(reg_wdata[NVMAC_BIT_WR])
      && $past(reg_addr) == NVMAC_OFF_CONTROL;
  endproperty
  a_start: assert property (p_start)
    else $error("write began without a start write");
  property p_len;
    $fell(write_busy) && !$past(ext_reset_req) && !$past(wdt_reset_req)
      |-> busy_cnt_reg inside {[9'h0c7:9'h0c9]};
  endproperty
  a_len: assert property (p_len)
    else $error("write cycle length wrong");
  property p_bound; write_busy |-> busy_cnt_reg < 9'h0ca; endproperty
  a_bound: assert property (p_bound)
    else $error("write cycle never ends");
  property p_abort;
    ce && write_busy && (ext_reset_req || wdt_reset_req) |=> !write_busy;
  endproperty
  a_abort: assert property (p_abort)
    else $error("reset did not cut the cycle");
  property p_addr; write_busy ##1 write_busy |-> $stable(mem_cmd.addr);
  endproperty
  a_addr: assert property (p_addr)
    else $error("address moved during write");
  property p_erase;
    $fell(write_busy) && $past(mem_cmd.erase) && !$past(ext_reset_req)
      && !$past(wdt_reset_req) |-> !mem_cmd.erase;
  endproperty
  a_erase: assert property (p_erase)
    else $error("row erase select not cleared");
endmodule

bind nvmac_ctrl nvmac_chk u_chk (.clk(clk), .nrst(nrst), .ce(ce),
  .ext_reset_req(ext_reset_req), .wdt_reset_req(wdt_reset_req),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_cmd(mem_cmd),
  .write_busy(write_busy));

// >>> nvmac_tb.sv
module tb
  import nvmac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, nrst, ce, ext_rq, wdt_rq, reg_wr, reg_rd, write_busy, irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, mem_rdata;
  logic [15:0] tp;
  nvmac_mem_s mem_cmd;
  int         failures, checked, cyc;

  // array stand-in: byte derived from the address
  assign mem_rdata = mem_cmd.addr[7:0] ^ mem_cmd.addr[15:8] ^ 8'h3c;

  nvmac_ctrl dut (.clk(clk), .nrst(nrst), .ce(ce), .ext_reset_req(ext_rq),
    .wdt_reset_req(wdt_rq), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_cmd(mem_cmd), .mem_rdata(mem_rdata), .table_pointer(tp),
    .write_busy(write_busy), .irq(irq));

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // idle cycle after each write keeps one strobe edge per step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e);
    @(posedge clk);
  endtask
  task automatic arm;
    wr(NVMAC_OFF_UNLOCK, NVMAC_KEY_FIRST);
    wr(NVMAC_OFF_UNLOCK, NVMAC_KEY_SECOND);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic s_reset;
    rdc(NVMAC_OFF_CONTROL, NVMAC_CTRL_RST);
    rdc(NVMAC_OFF_DATA, NVMAC_BYTE_RST);
    rdc(4'hf, 8'h00);
  endtask
  task automatic s_read;
    wr(NVMAC_OFF_ADDR_LO, 8'h12);
    wr(NVMAC_OFF_ADDR_HI, 8'h34);
    reg_addr <= NVMAC_OFF_CONTROL;
    reg_wdata <= 8'h01;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    rdc(NVMAC_OFF_DATA, 8'h12 ^ 8'h34 ^ 8'h3c);
    wr(NVMAC_OFF_ADDR_LO, 8'h56);
    rdc(NVMAC_OFF_DATA, 8'h12 ^ 8'h34 ^ 8'h3c);
    // config space selected: the read strobe must not load the byte
    wr(NVMAC_OFF_CONTROL, 8'h41);
    chk(mem_cmd.cfg, 1'b1);
    rdc(NVMAC_OFF_DATA, 8'h12 ^ 8'h34 ^ 8'h3c);
    rdc(NVMAC_OFF_CONTROL, 8'h40);
  endtask
  task automatic s_write;
    int n;
    n = 0;
    wr(NVMAC_OFF_MASK, 8'h01);
    wr(NVMAC_OFF_DATA, 8'h5a);
    wr(NVMAC_OFF_CONTROL, 8'h04);
    arm;
    wr(NVMAC_OFF_CONTROL, 8'h06);
    @(negedge clk);
    chk(write_busy, 1'b1);
    chk(mem_cmd.we, 1'b1);
    chk(mem_cmd.wdata, 8'h5a);
    @(posedge clk);
    wr(NVMAC_OFF_CONTROL, 8'h04);
    rdc(NVMAC_OFF_CONTROL, 8'h06);
    while (write_busy === 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(n > NVMAC_WRITE_CYC - 12 && n <= NVMAC_WRITE_CYC, 1'b1);
    chk(irq, 1'b1);
    @(posedge clk);
    rdc(NVMAC_OFF_CONTROL, 8'h04);
    rdc(NVMAC_OFF_STATUS, 8'h01);
    wr(NVMAC_OFF_STATUS, 8'h01);
    rdc(NVMAC_OFF_STATUS, 8'h00);
  endtask
  task automatic s_nolock;
    wr(NVMAC_OFF_CONTROL, 8'h06);
    wr(NVMAC_OFF_UNLOCK, NVMAC_KEY_SECOND);
    wr(NVMAC_OFF_UNLOCK, NVMAC_KEY_FIRST);
    wr(NVMAC_OFF_CONTROL, 8'h06);
    rdc(NVMAC_OFF_CONTROL, 8'h04);
    wr(NVMAC_OFF_CONTROL, 8'h00);
    arm;
    wr(NVMAC_OFF_CONTROL, 8'h02);
    rdc(NVMAC_OFF_CONTROL, 8'h00);
    // permit and start in one write: permit lands, start does not
    arm;
    wr(NVMAC_OFF_CONTROL, 8'h06);
    rdc(NVMAC_OFF_CONTROL, 8'h04);
  endtask
  // c picks the cause: 0 external pin, 1 watchdog
  task automatic s_abort(input int c);
    wr(NVMAC_OFF_CONTROL, 8'h94);
    arm;
    wr(NVMAC_OFF_CONTROL, 8'h96);
    @(negedge clk);
    chk(mem_cmd.erase, 1'b1);
    chk(mem_cmd.pgm, 1'b1);
    chk(mem_cmd.addr, tp);
    @(posedge clk);
    ext_rq <= (c == 0);
    wdt_rq <= (c == 1);
    @(posedge clk);
    ext_rq <= 1'b0;
    wdt_rq <= 1'b0;
    rdc(NVMAC_OFF_CONTROL, 8'h9c);
    rdc(NVMAC_OFF_STATUS, 8'h02);
    chk(irq, 1'b0);
    wr(NVMAC_OFF_MASK, 8'h03);
    chk(irq, 1'b1);
    wr(NVMAC_OFF_STATUS, 8'h03);
    wr(NVMAC_OFF_MASK, 8'h01);
  endtask
  // a row erase that runs to the end drops its own erase select
  task automatic s_erase;
    int n;
    n = 0;
    wr(NVMAC_OFF_CONTROL, 8'h94);
    arm;
    wr(NVMAC_OFF_CONTROL, 8'h96);
    while (write_busy === 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(n > NVMAC_WRITE_CYC - 12 && n <= NVMAC_WRITE_CYC, 1'b1);
    chk(mem_cmd.erase, 1'b0);
    @(posedge clk);
    rdc(NVMAC_OFF_CONTROL, 8'h84);
    rdc(NVMAC_OFF_STATUS, 8'h01);
    wr(NVMAC_OFF_STATUS, 8'h01);
  endtask

  task automatic tally_and_finish;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, timeout and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // a hung wait must not stall the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish;
    end
  end
  initial begin
    {nrst, ext_rq, wdt_rq, reg_wr, reg_rd} <= 5'h00;
    ce <= 1'b1;
    reg_addr <= 4'h0;
    reg_wdata <= 8'h00;
    tp <= 16'h0a40;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    s_reset;
    s_read;
    s_write;
    s_nolock;
    for (int i = 0; i < 2; i++) begin
      s_abort(i);
    end
    s_erase;
    tally_and_finish;
  end
endmodule
